// ### verilog/uart_rx_pkg.sv
// Constants, field layout and types for the receive control block
package uart_rx_pkg;
  // Timing
  localparam int unsigned SYS_CLK_HZ      = 20_000_000;
  localparam int unsigned BAUD_RATE       = 9600;
  localparam int unsigned SAMPLE_DIV      = SYS_CLK_HZ / (16 * BAUD_RATE);
  localparam int unsigned CT_CLK_HZ       = 1_000_000;
  localparam int unsigned CT_DIV          = SYS_CLK_HZ / CT_CLK_HZ;
  localparam int unsigned OVR_GRACE_TICKS = 6;
  localparam int unsigned WDOG_BITS       = 64;
  localparam int unsigned BRK_END_EDGES   = 2;
  localparam int unsigned QUEUE_DEPTH     = 8;
  // Register offsets
  localparam logic [3:0] ADDR_MODE0   = 4'h0;
  localparam logic [3:0] ADDR_MODE1   = 4'h1;
  localparam logic [3:0] ADDR_STATUS  = 4'h2;
  localparam logic [3:0] ADDR_COMMAND = 4'h3;
  localparam logic [3:0] ADDR_RXDATA  = 4'h4;
  localparam logic [3:0] ADDR_ISR     = 4'h5;
  localparam logic [3:0] ADDR_IMR     = 4'h6;
  localparam logic [3:0] ADDR_CTU     = 4'h7;
  localparam logic [3:0] ADDR_CTL     = 4'h8;
  localparam logic [3:0] ADDR_CTCTRL  = 4'h9;
  // Reset values
  localparam logic [7:0] MODE0_RST = 8'h00;
  localparam logic [7:0] MODE1_RST = 8'h00;
  localparam logic [7:0] IMR_RST   = 8'h00;
  localparam logic [7:0] CTU_RST   = 8'h00;
  localparam logic [7:0] CTL_RST   = 8'h00;
  // Field positions
  localparam int M0_TURNAROUND = 0;
  localparam int M0_WDOG_EN    = 7;
  localparam int M1_MDROP_LO   = 3;
  localparam int M1_MDROP_HI   = 4;
  localparam int M1_BLOCK_ERR  = 5;
  localparam int M1_FLOW_EN    = 7;
  localparam int ST_AVAIL      = 0;
  localparam int ST_FULL       = 1;
  localparam int ST_OVERRUN    = 4;
  localparam int ST_PARITY     = 5;
  localparam int ST_FRAMING    = 6;
  localparam int ST_BREAK      = 7;
  localparam int IS_RX         = 1;
  localparam int IS_BRK_CHG    = 2;
  localparam int IS_CT_READY   = 3;
  localparam int IS_WDOG       = 6;
  localparam int CMD_RX_EN     = 0;
  localparam int CMD_RX_DIS    = 1;
  localparam int CT_START      = 0;
  localparam int CT_STOP_BIT   = 1;
  // Command codes, upper nibble
  localparam logic [3:0] CMD_RX_RESET  = 4'h2;
  localparam logic [3:0] CMD_ERR_RESET = 4'h4;
  localparam logic [3:0] CMD_BRK_CLR   = 4'h5;
  localparam logic [3:0] CMD_TMO_ON    = 4'ha;
  localparam logic [3:0] CMD_TMO_OFF   = 4'hc;

  typedef struct packed {
    logic       brk;
    logic       ferr;
    logic       perr;
    logic [7:0] data;
  } rx_entry_t;

  typedef enum {CT_IDLE, CT_RUN, CT_HALT, CT_LOAD} ct_state_t;
endpackage : uart_rx_pkg

// ### verilog/queue_mem_if.sv
// Write and read signals between queue control and its storage
`timescale 1ns/1ns
interface queue_mem_if
  import uart_rx_pkg::*;
  #(parameter int DEPTH = QUEUE_DEPTH);
  localparam int AW = $clog2(DEPTH);
  logic            we;
  logic [AW-1:0]   waddr;
  logic [AW-1:0]   raddr;
  rx_entry_t       wdata;
  rx_entry_t       rdata;
  modport ctrl (output we, waddr, raddr, wdata, input rdata);
  modport mem  (input we, waddr, raddr, wdata, output rdata);
endinterface : queue_mem_if

// ### verilog/rx_queue_mem.sv
// Storage of queued characters with registered read data
`timescale 1ns/1ns
module rx_queue_mem
  import uart_rx_pkg::*;
  #(parameter int DEPTH = QUEUE_DEPTH)
  (
  input wire logic i_sys_clk,
  queue_mem_if.mem q
  );
  rx_entry_t store [DEPTH];

  always_ff @(posedge i_sys_clk)
  begin
    if (q.we)
      store[q.waddr] <= q.wdata;
  end

  // Bypass keeps the head correct when it is written this cycle
  always_ff @(posedge i_sys_clk)
  begin
    if (q.we && q.waddr == q.raddr)
      q.rdata <= q.wdata;
    else
      q.rdata <= store[q.raddr];
  end
endmodule : rx_queue_mem

// ### verilog/uart_rx_status_flow_timeout.sv
// Receive status, flow control, watchdog and timeout counter control
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module uart_rx_status_flow_timeout
  import uart_rx_pkg::*;
  #(
  parameter int DEPTH      = QUEUE_DEPTH,
  parameter int SAMP_DIV   = SAMPLE_DIV,
  parameter int CTR_DIV    = CT_DIV
  )
  (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rd_data,
  input  wire logic       i_rxd,
  input  wire logic       i_start_valid,
  input  wire logic       i_char_done,
  input  wire logic [7:0] i_char_data,
  input  wire logic       i_char_perr,
  input  wire logic       i_char_ferr,
  input  wire logic       i_char_brk,
  input  wire logic       i_char_addr_tag,
  input  wire logic       i_tx_empty,
  input  wire logic       i_peer_load,
  input  wire logic       i_peer_timeout_on,
  output logic            o_rx_enable,
  output logic            o_timeout_on,
  output logic            o_char_load,
  output logic            o_flow_ready_out_n,
  output logic            o_irq
  );
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  queue_mem_if #(.DEPTH(DEPTH)) qif ();

  rx_queue_mem #(.DEPTH(DEPTH)) u_mem (
    .i_sys_clk (i_sys_clk),
    .q         (qif.mem)
  );

  logic [7:0]    mode_register_zero;
  logic [7:0]    mode_register_one;
  logic [7:0]    interrupt_mask_reg;
  logic [7:0]    counter_preset_upper;
  logic [7:0]    counter_preset_lower;
  logic          rx_enabled;
  logic          timeout_on;
  logic          rxd_meta;
  logic          rxd_sync;
  logic [15:0]   samp_cnt;
  logic [3:0]    sub_cnt;
  logic          samp_tick;
  logic          bit_tick;
  logic [15:0]   ct_div_cnt;
  logic          ct_tick;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic          char_available_flag;
  rx_entry_t     hold;
  logic          hold_valid;
  logic          overrun;
  logic          grace_active;
  logic [2:0]    grace_cnt;
  logic          rts_negated;
  logic          brk_active;
  logic [1:0]    brk_hi_cnt;
  logic          brk_change;
  logic [2:0]    acc_status;
  logic [6:0]    wd_cnt;
  logic          wd_flag;
  logic [15:0]   ct_value;
  logic          ct_ready;
  ct_state_t     ct_state;

  logic          wr_cmd;
  logic [3:0]    cmd_hi;
  logic          rx_reset;
  logic          err_reset;
  logic          multidrop;
  logic          accept;
  logic          full;
  logic          slot_free;
  logic          pop;
  logic          push_hold;
  logic          push_new;
  logic          push;
  logic          ct_restart;
  logic          ct_expire;
  logic [15:0]   preset;
  logic [2:0]    head_status;
  logic [2:0]    shown_status;
  logic [7:0]    channel_status_reg;
  logic [7:0]    interrupt_status_reg;

  assign wr_cmd    = i_wr && i_addr == ADDR_COMMAND;
  assign cmd_hi    = i_wr_data[7:4];
  assign rx_reset  = wr_cmd && cmd_hi == CMD_RX_RESET;
  assign err_reset = wr_cmd && cmd_hi == CMD_ERR_RESET;
  assign multidrop = mode_register_one[M1_MDROP_HI]
                   && mode_register_one[M1_MDROP_LO];
  assign preset    = {counter_preset_upper, counter_preset_lower};
  assign full      = count == FULL_CNT;

  // Character intake
  assign accept = i_char_done && !rx_reset
                && (rx_enabled || (multidrop && i_char_addr_tag));
  assign pop = i_rd && i_addr == ADDR_RXDATA && count != '0;
  assign slot_free = !full || pop;
  assign push_hold = hold_valid && slot_free;
  assign push_new  = accept && !hold_valid && slot_free;
  assign push      = (push_hold || push_new) && !rx_reset;

  assign qif.we    = push;
  assign qif.waddr = wr_ptr;
  assign qif.wdata = push_hold ? hold
                   : rx_entry_t'{i_char_brk, i_char_ferr, i_char_perr,
                                 i_char_data};
  assign qif.raddr = rx_reset ? '0 : (pop ? rd_ptr + 1'b1 : rd_ptr);

  assign head_status  = char_available_flag
                      ? {qif.rdata.brk, qif.rdata.ferr, qif.rdata.perr}
                      : 3'b000;
  assign shown_status = mode_register_one[M1_BLOCK_ERR]
                      ? acc_status : head_status;

  always_comb
  begin
    channel_status_reg              = 8'h00;
    channel_status_reg[ST_AVAIL]    = char_available_flag;
    channel_status_reg[ST_FULL]     = full;
    channel_status_reg[ST_OVERRUN]  = overrun;
    channel_status_reg[ST_PARITY]   = shown_status[0];
    channel_status_reg[ST_FRAMING]  = shown_status[1];
    channel_status_reg[ST_BREAK]    = shown_status[2];
  end

  always_comb
  begin
    interrupt_status_reg              = 8'h00;
    interrupt_status_reg[IS_RX]       = char_available_flag
                                      && (rx_enabled || multidrop);
    interrupt_status_reg[IS_BRK_CHG]  = brk_change;
    interrupt_status_reg[IS_CT_READY] = ct_ready;
    interrupt_status_reg[IS_WDOG]     = wd_flag
                                      && mode_register_zero[M0_WDOG_EN];
  end

  // Pin synchroniser
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end
    else
    begin
      rxd_meta <= i_rxd;
      rxd_sync <= rxd_meta;
    end
  end

  // Sample and bit rate enables
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      samp_cnt <= '0;
      sub_cnt  <= '0;
    end
    else if (samp_tick)
    begin
      samp_cnt <= '0;
      sub_cnt  <= sub_cnt + 4'h1;
    end
    else
      samp_cnt <= samp_cnt + 16'h0001;
  end
  assign samp_tick = samp_cnt == 16'(SAMP_DIV - 1);
  assign bit_tick  = samp_tick && sub_cnt == 4'hf;

  // Counter clock enable
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || ct_tick)
      ct_div_cnt <= '0;
    else
      ct_div_cnt <= ct_div_cnt + 16'h0001;
  end
  assign ct_tick = ct_div_cnt == 16'(CTR_DIV - 1);

  // Software registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      mode_register_zero   <= MODE0_RST;
      mode_register_one    <= MODE1_RST;
      interrupt_mask_reg   <= IMR_RST;
      counter_preset_upper <= CTU_RST;
      counter_preset_lower <= CTL_RST;
    end
    else if (i_wr)
    begin
      unique case (i_addr)
        ADDR_MODE0:  mode_register_zero   <= i_wr_data;
        ADDR_MODE1:  mode_register_one    <= i_wr_data;
        ADDR_IMR:    interrupt_mask_reg   <= i_wr_data;
        ADDR_CTU:    counter_preset_upper <= i_wr_data;
        ADDR_CTL:    counter_preset_lower <= i_wr_data;
        default:     ;
      endcase
    end
  end

  // Receiver enable and timeout mode
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || rx_reset)
      rx_enabled <= 1'b0;
    else if (wr_cmd && i_wr_data[CMD_RX_DIS])
      rx_enabled <= 1'b0;
    else if (wr_cmd && i_wr_data[CMD_RX_EN])
      rx_enabled <= 1'b1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      timeout_on <= 1'b0;
    else if (wr_cmd && cmd_hi == CMD_TMO_ON)
      timeout_on <= 1'b1;
    else if (wr_cmd && cmd_hi == CMD_TMO_OFF)
      timeout_on <= 1'b0;
  end

  // Queue pointers and holding register
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || rx_reset)
    begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      hold_valid <= 1'b0;
      hold       <= '0;
      char_available_flag <= 1'b0;
    end
    else
    begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count  <= count + CW'(push) - CW'(pop);
      char_available_flag <= count != '0;
      if (accept && !push_new)
      begin
        hold       <= qif.wdata.data == i_char_data && !push_hold
                    ? qif.wdata
                    : rx_entry_t'{i_char_brk, i_char_ferr, i_char_perr,
                                  i_char_data};
        hold_valid <= 1'b1;
      end
      else if (push_hold)
        hold_valid <= 1'b0;
    end
  end

  // Overrun grace window after start bit
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || rx_reset || pop)
    begin
      grace_active <= 1'b0;
      grace_cnt    <= '0;
    end
    else if (i_start_valid && full && hold_valid && !grace_active
             && !overrun && rx_enabled)
    begin
      grace_active <= 1'b1;
      grace_cnt    <= '0;
    end
    else if (grace_active && samp_tick)
    begin
      if (grace_cnt == 3'(OVR_GRACE_TICKS - 1))
        grace_active <= 1'b0;
      grace_cnt <= grace_cnt + 3'h1;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || rx_reset)
      overrun <= 1'b0;
    else if (grace_active && samp_tick && !pop
             && grace_cnt == 3'(OVR_GRACE_TICKS - 1))
      overrun <= 1'b1;
    else if (err_reset)
      overrun <= 1'b0;
  end

  // Accumulated status for block mode
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || rx_reset)
      acc_status <= 3'b000;
    else if (err_reset)
      acc_status <= head_status;
    else
      acc_status <= acc_status | head_status;
  end

  // Break tracking
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || rx_reset)
    begin
      brk_active <= 1'b0;
      brk_hi_cnt <= '0;
    end
    else if (i_char_done && i_char_brk && !brk_active)
    begin
      brk_active <= 1'b1;
      brk_hi_cnt <= '0;
    end
    else if (brk_active && bit_tick)
    begin
      if (!rxd_sync)
        brk_hi_cnt <= '0;
      else if (brk_hi_cnt == 2'(BRK_END_EDGES - 1))
        brk_active <= 1'b0;
      else
        brk_hi_cnt <= brk_hi_cnt + 2'h1;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || rx_reset)
      brk_change <= 1'b0;
    else if ((i_char_done && i_char_brk && !brk_active)
             || (brk_active && bit_tick && rxd_sync
                 && brk_hi_cnt == 2'(BRK_END_EDGES - 1)))
      brk_change <= 1'b1;
    else if (wr_cmd && cmd_hi == CMD_BRK_CLR)
      brk_change <= 1'b0;
  end

  // Flow control output
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || rx_reset)
      rts_negated <= 1'b0;
    else if (mode_register_one[M1_FLOW_EN] && i_start_valid && full)
      rts_negated <= 1'b1;
    else if (!full || !mode_register_one[M1_FLOW_EN])
      rts_negated <= 1'b0;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      o_flow_ready_out_n <= 1'b0;
    else if (mode_register_zero[M0_TURNAROUND])
      o_flow_ready_out_n <= !i_tx_empty;
    else
      o_flow_ready_out_n <= rts_negated;
  end

  // Watchdog
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || rx_reset || push || pop)
    begin
      wd_cnt  <= '0;
      wd_flag <= 1'b0;
    end
    else if (rx_enabled && bit_tick && !wd_flag)
    begin
      if (wd_cnt == 7'(WDOG_BITS - 1))
        wd_flag <= 1'b1;
      wd_cnt <= wd_cnt + 7'h01;
    end
  end

  // Counter/timer
  assign ct_restart = timeout_on
                    && (push || (i_peer_load && i_peer_timeout_on));
  assign ct_expire  = ct_state == CT_RUN && ct_tick && ct_value == '0;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      ct_state <= CT_IDLE;
      ct_value <= '0;
    end
    else if (wr_cmd && cmd_hi == CMD_TMO_ON)
      ct_state <= CT_IDLE;
    else if (ct_restart)
      ct_state <= CT_HALT;
    else if (!timeout_on && i_wr && i_addr == ADDR_CTCTRL)
    begin
      if (i_wr_data[CT_STOP_BIT])
        ct_state <= CT_IDLE;
      else if (i_wr_data[CT_START])
      begin
        ct_state <= CT_RUN;
        ct_value <= preset;
      end
    end
    else if (ct_tick)
    begin
      unique case (ct_state)
        CT_IDLE: ;
        CT_HALT:
        begin
          ct_state <= CT_LOAD;
          ct_value <= preset;
        end
        CT_LOAD: ct_state <= CT_RUN;
        CT_RUN:
        begin
          if (ct_value != '0)
            ct_value <= ct_value - 16'h0001;
          else if (timeout_on)
            ct_state <= CT_IDLE;
          else
            ct_value <= preset;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      ct_ready <= 1'b0;
    else if (ct_expire && !ct_restart)
      ct_ready <= 1'b1;
    else if (ct_restart || (wr_cmd && cmd_hi == CMD_TMO_ON))
      ct_ready <= 1'b0;
  end

  // Bus read port and outputs
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      o_rd_data <= 8'h00;
    else if (i_rd)
    begin
      unique case (i_addr)
        ADDR_MODE0:  o_rd_data <= mode_register_zero;
        ADDR_MODE1:  o_rd_data <= mode_register_one;
        ADDR_STATUS: o_rd_data <= channel_status_reg;
        ADDR_RXDATA: o_rd_data <= pop ? qif.rdata.data : 8'h00;
        ADDR_ISR:    o_rd_data <= interrupt_status_reg;
        ADDR_IMR:    o_rd_data <= interrupt_mask_reg;
        ADDR_CTU:    o_rd_data <= counter_preset_upper;
        ADDR_CTL:    o_rd_data <= counter_preset_lower;
        default:     o_rd_data <= 8'h00;
      endcase
    end
    else
      o_rd_data <= 8'h00;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_irq        <= 1'b0;
      o_rx_enable  <= 1'b0;
      o_timeout_on <= 1'b0;
      o_char_load  <= 1'b0;
    end
    else
    begin
      o_irq        <= |(interrupt_status_reg & interrupt_mask_reg);
      o_rx_enable  <= rx_enabled && !rx_reset
                   && !(wr_cmd && i_wr_data[CMD_RX_DIS]);
      o_timeout_on <= timeout_on;
      o_char_load  <= push;
    end
  end
endmodule : uart_rx_status_flow_timeout

// ### dv/uart_rx_asserts.sv
// Port checks of the receive control block and their bind
`timescale 1ns/1ns
module uart_rx_asserts
  import uart_rx_pkg::*;
  (
  input wire logic       i_sys_clk,
  input wire logic       i_reset,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rd_data,
  input wire logic       i_char_done,
  input wire logic       i_char_addr_tag,
  input wire logic       o_rx_enable,
  input wire logic       o_timeout_on,
  input wire logic       o_char_load
  );
  logic       cmd;
  logic       en_c;
  logic       dis_c;
  logic [3:0] op;
  assign cmd = i_wr && i_addr == ADDR_COMMAND;
  assign op = i_wr_data[7:4];
  assign dis_c = cmd && (i_wr_data[CMD_RX_DIS] || op == CMD_RX_RESET);
  assign en_c = cmd && i_wr_data[CMD_RX_EN] && !dis_c;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  a_reply_only: assert property (!$past(i_rd) |-> o_rd_data == 8'h00)
    else $error("read data outside reply cycle");
  a_load_cause: assert property (o_char_load |->
    $past(i_char_done) || $past(i_rd) || $past(i_rd, 2))
    else $error("queue load without cause");
  a_enable_cmd: assert property (en_c ##1 !cmd |=> o_rx_enable)
    else $error("enable command ignored");
  a_disable_cmd: assert property (dis_c |=> !o_rx_enable)
    else $error("disable or reset command ignored");
  a_stay_off: assert property (!o_rx_enable && !en_c &&
    !$past(en_c) |=> !o_rx_enable)
    else $error("receiver enabled without command");
  a_stay_on: assert property (o_rx_enable && !dis_c |=> o_rx_enable)
    else $error("receiver dropped without command");
  a_tmo_on: assert property (cmd && op == CMD_TMO_ON ##1 !cmd
    |=> o_timeout_on)
    else $error("timeout on command ignored");
  a_tmo_off: assert property (cmd && op == CMD_TMO_OFF ##1 !cmd
    |=> !o_timeout_on)
    else $error("timeout off command ignored");
  a_drop_off: assert property (!o_rx_enable && i_char_done &&
    !i_char_addr_tag && !i_rd |=> !o_char_load)
    else $error("disabled receiver stored a character");
  c_enable: cover property (en_c);
  c_load_tmo: cover property (o_char_load && o_timeout_on);
  c_drop: cover property (!o_rx_enable && i_char_done);
endmodule : uart_rx_asserts

bind uart_rx_status_flow_timeout uart_rx_asserts chk (.i_sys_clk,
  .i_reset, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data, .i_char_done,
  .i_char_addr_tag, .o_rx_enable, .o_timeout_on, .o_char_load);

// ### dv/remote_tx_model.sv
// Remote transmitter and character assembler on the serial side
`timescale 1ns/1ns
module remote_tx_model
  (
  input  wire logic       i_sys_clk,
  input  wire logic       i_flow_ready_out_n,
  output logic            o_start = 1'b0,
  output logic            o_done = 1'b0,
  output logic      [7:0] o_data = 8'h00,
  output logic      [2:0] o_flags = 3'b000,
  output logic            o_tag = 1'b0,
  output logic            o_rxd = 1'b1
  );
  // One character; ign sends even while not ready
  task automatic send(input logic [7:0] d, input logic [2:0] f,
                      input logic tg, input logic ign);
    int n = 0;
    while (!ign && i_flow_ready_out_n && n < 500)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    @(posedge i_sys_clk);
    o_start <= 1'b1;
    o_rxd <= ~f[2];
    @(posedge i_sys_clk);
    o_start <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    o_done <= 1'b1;
    o_data <= d;
    o_flags <= f;
    o_tag <= tg;
    @(posedge i_sys_clk);
    o_done <= 1'b0;
    o_data <= ~d;
    o_flags <= ~f;
    o_tag <= ~tg;
    repeat (3) @(posedge i_sys_clk);
  endtask : send
endmodule : remote_tx_model

// ### dv/tb_top.sv
// Self-checking bench for the receive control block
`timescale 1ns/1ns
module tb_top;
  import uart_rx_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_tx_empty = 1'b1;
  logic        i_peer_load = 1'b0;
  logic        i_peer_timeout_on = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wr_data = 8'h00;
  logic [7:0]  o_rd_data, d, e, cdata;
  logic [7:0]  q [10];
  logic [15:0] seed = 16'h4751;
  logic [2:0]  flags;
  logic        start, done, tag, rxd, rx_en, tmo_on, load, rts_n, irq;
  logic [3:0]  ra [6] = '{ADDR_MODE0, ADDR_MODE1, ADDR_STATUS, ADDR_ISR,
                          ADDR_IMR, 4'hf};
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #25 i_sys_clk = ~i_sys_clk;

  uart_rx_status_flow_timeout #(.SAMP_DIV(2), .CTR_DIV(2)) dut (
    .i_sys_clk, .i_reset, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data,
    .i_rxd(rxd), .i_start_valid(start), .i_char_done(done),
    .i_char_data(cdata), .i_char_perr(flags[0]), .i_char_ferr(flags[1]),
    .i_char_brk(flags[2]), .i_char_addr_tag(tag), .i_tx_empty,
    .i_peer_load, .i_peer_timeout_on, .o_rx_enable(rx_en),
    .o_timeout_on(tmo_on), .o_char_load(load),
    .o_flow_ready_out_n(rts_n), .o_irq(irq));

  remote_tx_model rem (.i_sys_clk, .i_flow_ready_out_n(rts_n),
    .o_start(start), .o_done(done), .o_data(cdata), .o_flags(flags),
    .o_tag(tag), .o_rxd(rxd));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [7:0] stat(input logic [2:0] f,
                                      input logic ov, fu, av);
    return {f, ov, 2'b00, fu, av};
  endfunction : stat

  task automatic chk(input string nm, input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wr_data <= v;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    d = o_rd_data;
  endtask : rd

  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [7:0] x);
    rd(a);
    chk(nm, d, x);
  endtask : rchk

  task automatic ibit(input int b, input logic x);
    rd(ADDR_ISR);
    chk("isr", 8'(d[b]), 8'(x));
  endtask : ibit

  task automatic end_sim;
    $display("Checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  initial
  begin
    repeat (10000) @(posedge i_sys_clk);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    repeat (4) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    foreach (ra[i]) rchk("reset", ra[i], 8'h00);
    chk("rts", 8'(rts_n), 8'h00);
    $display("end reset");
    wr(ADDR_COMMAND, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      rem.send(seed[7:0], {1'b0, seed[9:8]}, 1'b0, 1'b0);
      e = stat({1'b0, seed[9:8]}, 1'b0, 1'b0, 1'b1);
      repeat (2) rchk("stat", ADDR_STATUS, e);
      rchk("data", ADDR_RXDATA, seed[7:0]);
    end
    rchk("empty", ADDR_RXDATA, 8'h00);
    $display("end char mode");
    wr(ADDR_MODE1, 8'h80);
    for (int i = 0; i < 10; i++)
    begin
      seed = lfsr(seed);
      q[i] = (i == 0) ? 8'hff : seed[7:0];
      rem.send(q[i], 3'b000, 1'b0, i == 9);
      if (i == 8)
      begin
        rchk("full", ADDR_STATUS, stat(3'b000, 1'b0, 1'b1, 1'b1));
        chk("rts", 8'(rts_n), 8'h01);
      end
    end
    repeat (20) @(posedge i_sys_clk);
    rchk("ovr", ADDR_STATUS, stat(3'b000, 1'b1, 1'b1, 1'b1));
    for (int i = 0; i < 8; i++)
    begin
      rchk("keep", ADDR_RXDATA, q[i]);
      repeat (3) @(negedge i_sys_clk);
      if (i == 1) chk("rts", 8'(rts_n), 8'h00);
    end
    rchk("last", ADDR_RXDATA, q[9]);
    rchk("sticky", ADDR_STATUS, stat(3'b000, 1'b1, 1'b0, 1'b0));
    wr(ADDR_COMMAND, 8'h40);
    rchk("errclr", ADDR_STATUS, 8'h00);
    $display("end overrun");
    wr(ADDR_MODE1, 8'h20);
    rem.send(8'h5a, 3'b001, 1'b0, 1'b0);
    rem.send(8'ha5, 3'b000, 1'b0, 1'b0);
    rchk("data", ADDR_RXDATA, 8'h5a);
    rchk("blk", ADDR_STATUS, stat(3'b001, 1'b0, 1'b0, 1'b1));
    rchk("data", ADDR_RXDATA, 8'ha5);
    wr(ADDR_COMMAND, 8'h40);
    rchk("blkclr", ADDR_STATUS, 8'h00);
    $display("end block mode");
    wr(ADDR_MODE1, 8'h00);
    rem.send(8'h00, 3'b100, 1'b0, 1'b0);
    ibit(IS_BRK_CHG, 1'b1);
    rchk("brk", ADDR_STATUS, stat(3'b100, 1'b0, 1'b0, 1'b1));
    wr(ADDR_COMMAND, 8'h50);
    repeat (80) @(posedge i_sys_clk);
    ibit(IS_BRK_CHG, 1'b0);
    rchk("data", ADDR_RXDATA, 8'h00);
    rem.send(8'h3c, 3'b000, 1'b0, 1'b0);
    repeat (80) @(posedge i_sys_clk);
    ibit(IS_BRK_CHG, 1'b1);
    $display("end break");
    wr(ADDR_IMR, 8'h02);
    wr(ADDR_COMMAND, 8'h02);
    rem.send(8'h77, 3'b000, 1'b0, 1'b0);
    chk("irq", 8'(irq), 8'h00);
    rchk("data", ADDR_RXDATA, 8'h3c);
    rchk("drop", ADDR_STATUS, 8'h00);
    wr(ADDR_MODE1, 8'h18);
    rem.send(8'h42, 3'b000, 1'b1, 1'b0);
    repeat (3) @(negedge i_sys_clk);
    chk("irq", 8'(irq), 8'h01);
    rem.send(8'h24, 3'b000, 1'b0, 1'b0);
    rchk("data", ADDR_RXDATA, 8'h42);
    rchk("none", ADDR_RXDATA, 8'h00);
    $display("end disable");
    wr(ADDR_MODE1, 8'h00);
    wr(ADDR_COMMAND, 8'h01);
    rem.send(8'h11, 3'b011, 1'b0, 1'b0);
    wr(ADDR_COMMAND, 8'h20);
    rchk("rxrst", ADDR_STATUS, 8'h00);
    chk("irq", 8'(irq), 8'h00);
    chk("en", 8'(rx_en), 8'h00);
    wr(ADDR_MODE0, 8'h01);
    @(posedge i_sys_clk);
    i_tx_empty <= 1'b0;
    repeat (3) @(negedge i_sys_clk);
    chk("turn", 8'(rts_n), 8'h01);
    @(posedge i_sys_clk);
    i_tx_empty <= 1'b1;
    repeat (3) @(negedge i_sys_clk);
    chk("turn", 8'(rts_n), 8'h00);
    $display("end reset and turnaround");
    wr(ADDR_MODE0, 8'h80);
    wr(ADDR_COMMAND, 8'h01);
    rem.send(8'h66, 3'b000, 1'b0, 1'b0);
    repeat (1950) @(posedge i_sys_clk);
    ibit(IS_WDOG, 1'b0);
    repeat (200) @(posedge i_sys_clk);
    ibit(IS_WDOG, 1'b1);
    $display("end watchdog");
    wr(ADDR_CTU, 8'h00);
    wr(ADDR_CTL, 8'h0a);
    wr(ADDR_IMR, 8'h08);
    wr(ADDR_COMMAND, 8'ha0);
    wr(ADDR_CTCTRL, 8'h01);
    repeat (60) @(posedge i_sys_clk);
    ibit(IS_CT_READY, 1'b0);
    rem.send(8'h99, 3'b000, 1'b0, 1'b0);
    ibit(IS_CT_READY, 1'b0);
    repeat (60) @(posedge i_sys_clk);
    ibit(IS_CT_READY, 1'b1);
    chk("irq", 8'(irq), 8'h01);
    @(posedge i_sys_clk);
    i_peer_timeout_on <= 1'b1;
    i_peer_load <= 1'b1;
    @(posedge i_sys_clk);
    i_peer_load <= 1'b0;
    ibit(IS_CT_READY, 1'b0);
    repeat (60) @(posedge i_sys_clk);
    ibit(IS_CT_READY, 1'b1);
    wr(ADDR_COMMAND, 8'ha0);
    ibit(IS_CT_READY, 1'b0);
    wr(ADDR_COMMAND, 8'hc0);
    repeat (2) @(negedge i_sys_clk);
    chk("tmo", 8'(tmo_on), 8'h00);
    $display("end timeout");
    end_sim();
  end
endmodule : tb_top
